// ===== src/phy_port_regs_pkg.sv
// Constants and carrier types for one port's status, identifier and advertisement registers
package phy_port_regs_pkg;

  // Register offsets below the port nibble
  localparam logic [11:0] off_status     = 12'h0102;
  localparam logic [11:0] off_ident_high = 12'h0104;
  localparam logic [11:0] off_ident_low  = 12'h0106;
  localparam logic [11:0] off_advert     = 12'h0108;

  // Basic status field positions
  localparam int pos_t4        = 15;
  localparam int pos_fd100     = 14;
  localparam int pos_hd100     = 13;
  localparam int pos_fd10      = 12;
  localparam int pos_hd10      = 11;
  localparam int pos_ext_stat  = 8;
  localparam int pos_preamble  = 6;
  localparam int pos_neg_done  = 5;
  localparam int pos_far_fault = 4;
  localparam int pos_neg_able  = 3;
  localparam int pos_link      = 2;
  localparam int pos_jabber    = 1;
  localparam int pos_ext_cap   = 0;

  // Fixed ones of the status word: speed abilities, preamble, negotiation able, extended caps
  localparam logic [15:0] status_fixed = 16'h7849;

  // Advertisement reset value and the bits software may write
  localparam logic [15:0] advert_reset = 16'h05E1;
  localparam logic [15:0] advert_wmask = 16'hADFF;
  localparam int          pos_adv_t4   = 9;

  // Pause field encodings
  localparam logic [1:0] pause_none = 2'h0;
  localparam logic [1:0] pause_sym  = 2'h1;
  localparam logic [1:0] pause_asym = 2'h2;
  localparam logic [1:0] pause_both = 2'h3;

  typedef struct packed {
    logic       next_page;
    logic       rsvd14;
    logic       far_fault;
    logic       rsvd12;
    logic [1:0] pause;
    logic       t4;
    logic       fd100;
    logic       hd100;
    logic       fd10;
    logic       hd10;
    logic [4:0] selector;
  } advert_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

// ===== src/phy_status_id_advert_regs.sv
// Per-port status, identifier and advertisement registers of an integrated copper transceiver
//
// How it works
// - status bit 15 always reads zero
// - status bits 14 to 11 read one
// - status bit 8 reads zero
// - status bit 6 reads one
// - status bit 5 shows negotiation done
// - far-end fault latches high until read
// - status bit 3 reads one
// - jabber latches high until read
// - status bit 0 reads one
// - high identifier word is fixed
// - low identifier word is fixed
// - next-page advert bit writable, resets zero
// - far-fault advert bit writable, resets zero
// - pause field writable, resets to symmetric
// - advert bit 9 always reads zero
// - four speed advert bits writable, reset one
// - restart renegotiates using current advertisement
`timescale 1ns/1ps
`default_nettype none

module phy_status_id_advert_regs #(
  parameter int          port_num   = 1,
  parameter logic [15:0] ident_high = 16'hA5C3,  // Arbitrary value
  parameter logic [15:0] ident_low  = 16'h5A3C   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // Register access from the switch register space
  input  wire phy_port_regs_pkg::reg_req_t req,
  output var  logic [15:0]                 rdata,
  output var  logic                        rdvalid,
  // Line and negotiation events
  input  wire logic                        link_up,
  input  wire logic                        far_fault,
  input  wire logic                        jabber,
  input  wire logic                        neg_done,
  // Negotiation engine
  input  wire logic                        restart_req,
  output var  logic                        neg_restart,
  output var  phy_port_regs_pkg::advert_t  advert
);

  // Only ports 1 to 5 exist; any other nibble would alias a foreign port's registers
  if (port_num < 1 || port_num > 5)
  begin : g_bad_port
    $error("port_num must lie between 1 and 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam logic [3:0] port_nib = 4'(port_num);

  wire logic hit_port    = (req.addr[15:12] == port_nib);
  wire logic hit_status  = hit_port && (req.addr[11:0] == phy_port_regs_pkg::off_status);
  wire logic hit_high    = hit_port && (req.addr[11:0] == phy_port_regs_pkg::off_ident_high);
  wire logic hit_low     = hit_port && (req.addr[11:0] == phy_port_regs_pkg::off_ident_low);
  wire logic hit_advert  = hit_port && (req.addr[11:0] == phy_port_regs_pkg::off_advert);
  wire logic rd_status   = req.rd && hit_status;
  wire logic wr_advert   = req.wr && hit_advert;

  ////////////////////////////////////////////////////////////////////////////
  // Latched status flags

  logic fault_latched;
  logic jabber_latched;
  logic link_latched;

  // An event in the reading cycle survives the clear
  wire logic next_fault  = far_fault || (fault_latched && !rd_status);
  wire logic next_jabber = jabber || (jabber_latched && !rd_status);
  // A loss holds the bit low; a read reloads the live state
  wire logic next_link   = rd_status ? link_up : (link_latched && link_up);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fault_latched  <= 1'b0;
      jabber_latched <= 1'b0;
      link_latched   <= 1'b0;
    end
    else
    begin
      fault_latched  <= next_fault;
      jabber_latched <= next_jabber;
      link_latched   <= next_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  logic [15:0] status_word;

  always_comb
  begin
    status_word = phy_port_regs_pkg::status_fixed;
    status_word[phy_port_regs_pkg::pos_neg_done]  = neg_done;
    status_word[phy_port_regs_pkg::pos_far_fault] = fault_latched;
    status_word[phy_port_regs_pkg::pos_link]      = link_latched;
    status_word[phy_port_regs_pkg::pos_jabber]    = jabber_latched;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement register

  // Reserved and read-only bits never take a write, so bit 9 stays zero
  wire logic [15:0] next_advert = (req.wdata & phy_port_regs_pkg::advert_wmask)
                                | (16'(advert) & ~phy_port_regs_pkg::advert_wmask);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      advert <= phy_port_regs_pkg::advert_reset;
    else if (wr_advert)
      advert <= next_advert;
  end

  // Restart is passed on one cycle later so the engine sees any write of the same cycle
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      neg_restart <= 1'b0;
    else
      neg_restart <= restart_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire logic [15:0] read_mux = hit_status ? status_word :
                               hit_high   ? ident_high  :
                               hit_low    ? ident_low   :
                               hit_advert ? 16'(advert) :
                                            16'h0000;

  logic was_status;
  logic was_high;
  logic was_low;
  logic was_advert;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rdata      <= 16'h0000;
      rdvalid    <= 1'b0;
      was_status <= 1'b0;
      was_high   <= 1'b0;
      was_low    <= 1'b0;
      was_advert <= 1'b0;
    end
    else
    begin
      rdvalid    <= req.rd;
      rdata      <= req.rd ? read_mux : 16'h0000;
      was_status <= rd_status;
      was_high   <= req.rd && hit_high;
      was_low    <= req.rd && hit_low;
      was_advert <= req.rd && hit_advert;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_status_read;
    rd_status ##1 rdvalid;
  endsequence

  // One idle cycle between event and read proves the latch holds on its own
  sequence s_fault_then_read;
    far_fault ##2 rd_status;
  endsequence

  property p_no_t4;
    s_status_read |-> !rdata[phy_port_regs_pkg::pos_t4];
  endproperty
  a_no_t4: assert property (p_no_t4) else $error("status bit 15 not zero");

  property p_speed_caps;
    was_status && rdvalid |-> rdata[14:11] == 4'hF;
  endproperty
  a_speed_caps: assert property (p_speed_caps) else $error("speed ability bits not set");

  property p_no_ext_status;
    was_status |-> !rdata[phy_port_regs_pkg::pos_ext_stat] && rdata[10:9] == 2'h0 && !rdata[7];
  endproperty
  a_no_ext_status: assert property (p_no_ext_status) else $error("extended status or reserved set");

  property p_preamble;
    was_status |-> rdata[phy_port_regs_pkg::pos_preamble];
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble suppression bit clear");

  property p_neg_done;
    rd_status |=> rdata[phy_port_regs_pkg::pos_neg_done] == $past(neg_done);
  endproperty
  a_neg_done: assert property (p_neg_done) else $error("negotiation done not live");

  property p_fault_held;
    s_fault_then_read |=> rdvalid && rdata[phy_port_regs_pkg::pos_far_fault];
  endproperty
  a_fault_held: assert property (p_fault_held) else $error("far fault lost before read");

  property p_fault_cleared;
    rd_status && !far_fault ##1 !far_fault |=> !fault_latched;
  endproperty
  a_fault_cleared: assert property (p_fault_cleared) else $error("far fault not cleared by read");

  property p_neg_able;
    was_status |-> rdata[phy_port_regs_pkg::pos_neg_able] && rdata[phy_port_regs_pkg::pos_ext_cap];
  endproperty
  a_neg_able: assert property (p_neg_able) else $error("ability bits clear");

  property p_link_loss;
    !link_up ##1 !rd_status |=> rd_status [*1] |=> !rdata[phy_port_regs_pkg::pos_link];
  endproperty
  a_link_loss: assert property (p_link_loss) else $error("link loss not latched");

  property p_link_reload;
    rd_status && link_up |=> link_latched;
  endproperty
  a_link_reload: assert property (p_link_reload) else $error("link not reloaded on read");

  property p_jabber_held;
    jabber ##2 rd_status |=> rdata[phy_port_regs_pkg::pos_jabber];
  endproperty
  a_jabber_held: assert property (p_jabber_held) else $error("jabber lost before read");

  property p_ext_cap;
    was_status |-> rdata[phy_port_regs_pkg::pos_ext_cap];
  endproperty
  a_ext_cap: assert property (p_ext_cap) else $error("extended capability clear");

  property p_ident_high;
    was_high |-> rdata == ident_high;
  endproperty
  a_ident_high: assert property (p_ident_high) else $error("high identifier wrong");

  property p_ident_low;
    was_low |-> rdata == ident_low;
  endproperty
  a_ident_low: assert property (p_ident_low) else $error("low identifier wrong");

  property p_adv_write;
    wr_advert |=> 16'(advert) == ($past(req.wdata) & phy_port_regs_pkg::advert_wmask);
  endproperty
  a_adv_write: assert property (p_adv_write) else $error("advertisement write wrong");

  property p_adv_t4;
    !advert.t4 && !advert.rsvd14 && !advert.rsvd12;
  endproperty
  a_adv_t4: assert property (p_adv_t4) else $error("advertisement read-only bit set");

  property p_adv_readback;
    was_advert |-> rdata == 16'($past(advert));
  endproperty
  a_adv_readback: assert property (p_adv_readback) else $error("advertisement readback wrong");

  property p_restart;
    restart_req |=> neg_restart ##1 !$past(neg_restart, 1) || neg_restart == $past(restart_req);
  endproperty
  a_restart: assert property (p_restart) else $error("restart not passed on");

  property p_adv_hold;
    !wr_advert |=> $stable(advert);
  endproperty
  a_adv_hold: assert property (p_adv_hold) else $error("advertisement changed without write");

  property p_jabber_cleared;
    rd_status && !jabber ##1 !jabber |=> !jabber_latched;
  endproperty
  a_jabber_cleared: assert property (p_jabber_cleared) else $error("jabber not cleared by read");

  property p_link_follow;
    !rd_status && !link_up |=> !link_latched;
  endproperty
  a_link_follow: assert property (p_link_follow) else $error("link loss not taken");

  property p_unmapped_zero;
    req.rd && !(hit_status || hit_high || hit_low || hit_advert) |=> rdvalid && rdata == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_adv_bit9_read;
    was_advert |-> !rdata[phy_port_regs_pkg::pos_adv_t4];
  endproperty
  a_adv_bit9_read: assert property (p_adv_bit9_read) else $error("advertisement bit 9 read as one");

  property p_restart_pulse;
    !restart_req |=> !neg_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart without request");

endmodule

`default_nettype wire

// ===== bench/phy_host_model.sv
// Management host model issuing single register reads and writes
`timescale 1ns/1ps
`default_nettype none

module phy_host_model (
  // Clock
  input  wire logic                        mclk,
  // Register requests
  output var  phy_port_regs_pkg::reg_req_t req
);
  initial req = '{rd: 1'b0, wr: 1'b0, addr: 16'h0000, wdata: 16'h0000};

  // Idle address and data are inverted so a stale value is never mistaken for a live one
  task automatic xfer(input logic is_wr, input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    req.rd    <= !is_wr;
    req.wr    <= is_wr;
    req.addr  <= a;
    req.wdata <= d;
    @(negedge mclk);
    req.rd    <= 1'b0;
    req.wr    <= 1'b0;
    req.addr  <= ~a;
    req.wdata <= ~d;
  endtask
endmodule

`default_nettype wire

// ===== bench/test_phy_status_id_advert_regs.sv
// Self-checking bench for one port's status, identifier and advertisement registers
`timescale 1ns/1ps
`default_nettype none

module test_phy_status_id_advert_regs;
  localparam logic [15:0] id_hi = 16'h3C69;  // Arbitrary value
  localparam logic [15:0] id_lo = 16'h96C3;  // Arbitrary value
  localparam logic [15:0] st    = 16'h3102;
  localparam logic [15:0] ih    = 16'h3104;
  localparam logic [15:0] il    = 16'h3106;
  localparam logic [15:0] ad    = 16'h3108;
  localparam logic [15:0] st_up = phy_port_regs_pkg::status_fixed | 16'h0024;

  logic                        mclk        = 1'b0;
  logic                        reset       = 1'b1;
  logic                        link_up     = 1'b1;
  logic                        far_fault   = 1'b0;
  logic                        jabber      = 1'b0;
  logic                        neg_done    = 1'b0;
  logic                        restart_req = 1'b0;
  logic                        neg_restart;
  logic                        rdvalid;
  logic [15:0]                 rdata;
  logic [15:0]                 d;
  phy_port_regs_pkg::reg_req_t req;
  phy_port_regs_pkg::advert_t  advert;
  logic [15:0]                 exp_q[$];
  int                          n_errors = 0;
  int                          n_checks = 0;

  always #5 mclk = ~mclk;

  phy_host_model u_host (
    .mclk (mclk),
    .req  (req)
  );

  phy_status_id_advert_regs #(
    .port_num   (3),
    .ident_high (id_hi),
    .ident_low  (id_lo)
  ) u_dut (
    .mclk        (mclk),
    .reset       (reset),
    .req         (req),
    .rdata       (rdata),
    .rdvalid     (rdvalid),
    .link_up     (link_up),
    .far_fault   (far_fault),
    .jabber      (jabber),
    .neg_done    (neg_done),
    .restart_req (restart_req),
    .neg_restart (neg_restart),
    .advert      (advert)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // The expectation is queued before the request so the monitor never runs ahead
  task automatic rd(input logic [15:0] a, input logic [15:0] want);
    exp_q.push_back(want);
    u_host.xfer(1'b0, a, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    u_host.xfer(1'b1, a, v);
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk)
  begin
    if (rdvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_errors++;
        $display("MISMATCH at %0t: read data with nothing expected", $time);
      end
      else
        check(rdata, exp_q.pop_front());
    end
  end

  initial
  begin
    #100000;
    n_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    void'($urandom(78239));
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    rd(st, phy_port_regs_pkg::status_fixed);
    rd(st, phy_port_regs_pkg::status_fixed | 16'h0004);
    neg_done = 1'b1;
    rd(st, st_up);
    rd(ih, id_hi);
    rd(il, id_lo);
    wr(ih, 16'hFFFF);
    wr(il, 16'h0000);
    rd(ih, id_hi);
    rd(il, id_lo);
    rd(ad, phy_port_regs_pkg::advert_reset);
    check(advert, phy_port_regs_pkg::advert_reset);
    // Fault, jabber, then a one-cycle link drop; each must survive until read
    for (int i = 0; i < 3; i++)
    begin
      @(negedge mclk);
      {far_fault, jabber, link_up} = 3'b001 ^ (3'b100 >> i);
      @(negedge mclk);
      // The read lands two cycles after the event, so the latch must hold one idle cycle
      {far_fault, jabber, link_up} = 3'b001;
      rd(st, (st_up | (16'h0010 >> (3 * i))) ^ ((i == 2) ? 16'h0004 : 16'h0000));
      rd(st, st_up);
    end
    // Reserved bits and bit 9 are always written as one to prove they are ignored
    for (int i = 0; i < 8; i++)
    begin
      d = 16'($urandom) | 16'h5200;
      d[11:10] = 2'(i);
      wr(ad, d);
      check(advert, d & phy_port_regs_pkg::advert_wmask);
      rd(ad, d & phy_port_regs_pkg::advert_wmask);
    end
    rd(16'h310A, 16'h0000);
    rd(16'h4102, 16'h0000);
    // A reset in mid-run must restore the advertisement and drop the link latch
    @(negedge mclk);
    reset = 1'b1;
    @(negedge mclk);
    reset = 1'b0;
    check(advert, phy_port_regs_pkg::advert_reset);
    rd(ad, phy_port_regs_pkg::advert_reset);
    rd(st, phy_port_regs_pkg::status_fixed | 16'h0020);
    @(negedge mclk);
    restart_req = 1'b1;
    @(negedge mclk);
    restart_req = 1'b0;
    check({15'h0000, neg_restart}, 16'h0001);
    @(negedge mclk);
    check({15'h0000, neg_restart}, 16'h0000);
    repeat (2) @(negedge mclk);
    check(16'(exp_q.size()), 16'h0000);
    finish_test;
  end
endmodule

`default_nettype wire
